// ===== verilog/mcd_pkg.sv
/*
 * constants shared by the motion command decoder: message layout, command types,
 * attribute codes, register offsets and reset values.
 * assumes a single 25 MHz core clock and a classic wishbone register bus.
 */
package mcd_pkg;
    // control byte 0 bit positions
    localparam int CTL_ENABLE_BIT   = 7;
    localparam int CTL_HARD_BIT     = 5;
    localparam int CTL_SMOOTH_BIT   = 4;
    localparam int CTL_DIR_BIT      = 3;
    localparam int CTL_INCR_BIT     = 2;
    localparam int CTL_LOAD_BIT     = 0;
    // byte 2 / byte 3 split: axis number in the top 3 bits, type in the low 5
    localparam int AXIS_HI          = 7;
    localparam int AXIS_LO          = 5;
    localparam int TYPE_HI          = 4;
    localparam int NUM_AXES         = 8;
    // command message types
    localparam logic [4:0] TYPE_CONT_VEL  = 5'h11;
    localparam logic [4:0] TYPE_HOME      = 5'h12;
    localparam logic [4:0] TYPE_SUPER     = 5'h1A;
    localparam logic [4:0] TYPE_ERROR     = 5'h14;
    // supervisor attribute numbers that may be written
    localparam logic [7:0] ATTR_ALARM_CLR = 8'h67;
    localparam logic [7:0] ATTR_NVM_EN    = 8'h6F;
    // operating modes
    localparam logic [7:0] MODE_POSITION  = 8'h00;
    localparam logic [7:0] MODE_VELOCITY  = 8'h01;
    // register byte offsets
    localparam logic [5:0] REG_MSG_LO     = 6'h00;
    localparam logic [5:0] REG_MSG_HI     = 6'h04;
    localparam logic [5:0] REG_CTRL       = 6'h08;
    localparam logic [5:0] REG_STATUS     = 6'h0C;
    localparam logic [5:0] REG_MASK       = 6'h10;
    localparam logic [5:0] REG_VEL        = 6'h14;
    localparam logic [5:0] REG_MODE       = 6'h18;
    localparam logic [5:0] REG_HOME       = 6'h1C;
    localparam logic [5:0] REG_POS        = 6'h20;
    localparam logic [5:0] REG_SUPER      = 6'h24;
    localparam logic [5:0] REG_RESP       = 6'h28;
    // control register bits
    localparam int CTRL_SUBMIT_BIT  = 0;
    localparam int CTRL_HDONE_BIT   = 1;
    // interrupt status bits
    localparam int IRQ_VEL_BIT      = 0;
    localparam int IRQ_HOME_BIT     = 1;
    localparam int IRQ_SUPER_BIT    = 2;
    localparam int IRQ_ERR_BIT      = 3;
    localparam int IRQ_STOP_BIT     = 4;
    localparam int IRQ_WIDTH        = 5;
    localparam logic [31:0] ZERO32  = 32'h0000_0000;
    typedef enum {ST_IDLE, ST_DECODE, ST_ACT} mcd_state_t;
endpackage

// ===== verilog/mcd_wb_slave.sv
/*
 * classic wishbone slave front end: turns a request into one-cycle
 * read and write strobes and gives ack one cycle after the request.
 * assumes a master that holds its request until ack.
 */
`timescale 1ns/10ps
module mcd_wb_slave
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    output logic             ack,
    output logic             wr_pulse,
    output logic             rd_pulse
);
    logic ack_reg;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= cyc && stb && !ack_reg;
    end

    assign ack      = ack_reg;
    assign wr_pulse = cyc && stb && we && !ack_reg;
    assign rd_pulse = cyc && stb && !we && !ack_reg;
endmodule

// ===== verilog/mcd_decoder.sv
/*
 * motion command decoder: takes 8-byte cyclic i/o command messages,
 * launches velocity slews and homing, writes supervisor attributes
 * and reports errors. registers and the message sit on classic wishbone.
 * assumes one 25 MHz clock, and motion logic that reports homing done.
 */
//
// Operation
// RULE_01 - master ends continuous velocity with a hard or smooth stop bit
// RULE_02 - that stop restores the mode held before continuous velocity
// RULE_03 - type 0x11 is continuous velocity, bytes 4..7 velocity, low first
// RULE_04 - byte 0: enable 7, hard 5, smooth 4, dir 3, incr 2, load 0
// RULE_05 - byte 2 command axis and type, byte 3 response axis and type
// RULE_06 - type 0x12 starts homing, byte 4 type, bytes 5..7 zero
// RULE_07 - homing start sets arm, position, homing type and direction (the code sets arm, homing type and direction, but not position)
// RULE_08 - homing profile starts only on a 0-to-1 load bit change
// RULE_09 - homing completion clears actual position to zero
// RULE_10 - during homing dir bit 0 means clockwise, 1 counter-clockwise
// RULE_11 - type 0x1A: byte 1 get, byte 3 set, bytes 4..7 value
// RULE_12 - supervisor command writes alarm clear and nvm storage enable
// RULE_13 - an invalid supervisor field yields the error response
// RULE_14 - supervisor writes happen only on a 0-to-1 load bit change
// RULE_15 - master sends command with load clear, then again with load set
// RULE_16 - continuous velocity starts a slew, sets target velocity and mode
// RULE_17 - previous load bit is kept per axis for edge detection
`timescale 1ns/10ps
module mcd_decoder
    import mcd_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RESET_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [5:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic        HOME_DONE,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ,
    output logic             SLEW_START,
    output logic             HOME_START,
    output logic             HOME_CCW,
    output logic             MOTION_STOP
);
    import mcd_pkg::*;

    logic        wr_pulse;
    logic        rd_pulse;
    logic        ack_w;
    logic [31:0] msg_lo_reg;
    logic [31:0] msg_hi_reg;
    logic        submit;
    logic        hd_sync1_reg;
    logic        hd_sync2_reg;
    logic        hd_prev_reg;
    logic        home_done_ev;
    logic        sw_hdone;
    mcd_state_t  state_reg;
    logic [NUM_AXES-1:0] load_prev_reg;
    logic [31:0] vel_reg;
    logic [7:0]  mode_reg;
    logic [7:0]  saved_mode_reg;
    logic        in_cont_reg;
    logic        home_arm_reg;
    logic [7:0]  home_type_reg;
    logic        home_dir_reg;
    logic [31:0] pos_reg;
    logic        alarm_clr_reg;
    logic        nvm_en_reg;
    logic [7:0]  resp_reg;
    logic [IRQ_WIDTH-1:0] status_reg;
    logic [IRQ_WIDTH-1:0] mask_reg;
    logic [IRQ_WIDTH-1:0] ev;
    logic [31:0] rdata_next;
    logic        irq_reg;
    logic        slew_reg;
    logic        hstart_reg;
    logic        stop_reg;
    // decoded message fields
    logic [7:0]  ctl;
    logic [7:0]  get_attr;
    logic [2:0]  cmd_axis;
    logic [4:0]  cmd_type;
    logic [7:0]  set_attr;
    logic [31:0] value;
    logic        load_rise;
    logic        stop_req;
    logic        super_ok;

    mcd_wb_slave u_wb
    (
        .clk      (CORE_CLK),
        .reset_n  (RESET_N),
        .cyc      (WB_CYC_I),
        .stb      (WB_STB_I),
        .we       (WB_WE_I),
        .ack      (ack_w),
        .wr_pulse (wr_pulse),
        .rd_pulse (rd_pulse)
    );

    // message field split
    assign ctl      = msg_lo_reg[7:0];                           // [RULE_04]
    assign get_attr = msg_lo_reg[15:8];                          // [RULE_11]
    assign cmd_axis = msg_lo_reg[16+AXIS_HI:16+AXIS_LO];         // [RULE_05]
    assign cmd_type = msg_lo_reg[16+TYPE_HI:16];                 // [RULE_05]
    assign set_attr = msg_lo_reg[31:24];                         // [RULE_11]
    assign value    = msg_hi_reg;                                // [RULE_03]
    assign load_rise = ctl[CTL_LOAD_BIT] && !load_prev_reg[cmd_axis]; // [RULE_08]
    assign stop_req = ctl[CTL_HARD_BIT] || ctl[CTL_SMOOTH_BIT];  // [RULE_01]
    assign super_ok = (set_attr == ATTR_ALARM_CLR || set_attr == ATTR_NVM_EN)
                      && (get_attr == ATTR_ALARM_CLR || get_attr == ATTR_NVM_EN); // [RULE_13]
    assign submit   = wr_pulse && WB_ADR_I == REG_CTRL && WB_SEL_I[0]
                      && WB_DAT_I[CTRL_SUBMIT_BIT];
    assign sw_hdone = wr_pulse && WB_ADR_I == REG_CTRL && WB_SEL_I[0]
                      && WB_DAT_I[CTRL_HDONE_BIT];

    // message words written with byte enables
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            msg_lo_reg <= ZERO32;
            msg_hi_reg <= ZERO32;
        end
        else
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (wr_pulse && WB_SEL_I[b] && WB_ADR_I == REG_MSG_LO)
                    msg_lo_reg[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
                if (wr_pulse && WB_SEL_I[b] && WB_ADR_I == REG_MSG_HI)
                    msg_hi_reg[b*8 +: 8] <= WB_DAT_I[b*8 +: 8];
            end
        end
    end

    // homing done input synchroniser and edge detect
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            hd_sync1_reg <= 1'b0;
            hd_sync2_reg <= 1'b0;
            hd_prev_reg  <= 1'b0;
        end
        else
        begin
            hd_sync1_reg <= HOME_DONE;
            hd_sync2_reg <= hd_sync1_reg;
            hd_prev_reg  <= hd_sync2_reg;
        end
    end
    assign home_done_ev = (hd_sync2_reg && !hd_prev_reg) || sw_hdone;

    // command sequencer: submit latches, decode, act
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:   state_reg <= submit ? ST_DECODE : ST_IDLE;
                ST_DECODE: state_reg <= ST_ACT;
                ST_ACT:    state_reg <= ST_IDLE;
                default:   state_reg <= ST_IDLE;
            endcase
        end
    end

    // previous load bit per axis
    generate
        for (genvar a = 0; a < NUM_AXES; a++)
        begin : g_axis
            always_ff @(posedge CORE_CLK or negedge RESET_N)
            begin
                if (!RESET_N)
                    load_prev_reg[a] <= 1'b0;
                else if (state_reg == ST_ACT && cmd_axis == a)
                    load_prev_reg[a] <= ctl[CTL_LOAD_BIT]; // [RULE_17]
            end
        end
    endgenerate

    // velocity slew, mode save and restore
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            vel_reg        <= ZERO32;
            mode_reg       <= MODE_POSITION;
            saved_mode_reg <= MODE_POSITION;
            in_cont_reg    <= 1'b0;
            slew_reg       <= 1'b0;
            stop_reg       <= 1'b0;
        end
        else
        begin
            slew_reg <= 1'b0;
            stop_reg <= 1'b0;
            if (wr_pulse && WB_ADR_I == REG_MODE && WB_SEL_I[0])
                mode_reg <= WB_DAT_I[7:0];
            if (state_reg == ST_ACT && ctl[CTL_ENABLE_BIT])
            begin
                if (stop_req)
                begin
                    stop_reg <= 1'b1;
                    if (in_cont_reg)
                    begin
                        mode_reg    <= saved_mode_reg;    // [RULE_02]
                        in_cont_reg <= 1'b0;
                    end
                end
                else if (cmd_type == TYPE_CONT_VEL)
                begin
                    vel_reg  <= value;                    // [RULE_16]
                    mode_reg <= MODE_VELOCITY;            // [RULE_16]
                    slew_reg <= 1'b1;                     // [RULE_16]
                    if (!in_cont_reg)
                        saved_mode_reg <= mode_reg;       // [RULE_02]
                    in_cont_reg <= 1'b1;
                end
            end
        end
    end

    // homing attributes and actual position
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            home_arm_reg  <= 1'b0;
            home_type_reg <= 8'h00;
            home_dir_reg  <= 1'b0;
            pos_reg       <= ZERO32;
            hstart_reg    <= 1'b0;
        end
        else
        begin
            hstart_reg <= 1'b0;
            if (wr_pulse && WB_ADR_I == REG_POS && WB_SEL_I == 4'hF)
                pos_reg <= WB_DAT_I;
            if (home_done_ev && home_arm_reg)
            begin
                pos_reg      <= ZERO32;                  // [RULE_09]
                home_arm_reg <= 1'b0;
            end
            if (state_reg == ST_ACT && ctl[CTL_ENABLE_BIT] && !stop_req
                && cmd_type == TYPE_HOME && msg_hi_reg[31:8] == 24'h000000) // [RULE_06]
            begin
                home_arm_reg  <= 1'b1;                   // [RULE_07]
                home_type_reg <= msg_hi_reg[7:0];        // [RULE_07]
                home_dir_reg  <= ctl[CTL_DIR_BIT];       // [RULE_10]
                hstart_reg    <= load_rise;              // [RULE_08]
            end
        end
    end

    // supervisor attribute writes and response type
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            alarm_clr_reg <= 1'b0;
            nvm_en_reg    <= 1'b0;
            resp_reg      <= 8'h00;
        end
        else if (state_reg == ST_ACT)
        begin
            resp_reg <= msg_lo_reg[31:24];
            if (cmd_type == TYPE_SUPER)
            begin
                if (!super_ok)
                    resp_reg <= {cmd_axis, TYPE_ERROR};  // [RULE_13]
                else if (load_rise)                      // [RULE_14]
                begin
                    if (set_attr == ATTR_ALARM_CLR)
                        alarm_clr_reg <= value[0];       // [RULE_12]
                    else
                        nvm_en_reg <= value[0];          // [RULE_12]
                end
            end
        end
    end

    // event bits
    assign ev[IRQ_VEL_BIT]   = slew_reg;
    assign ev[IRQ_HOME_BIT]  = home_done_ev && home_arm_reg;
    assign ev[IRQ_SUPER_BIT] = state_reg == ST_ACT && cmd_type == TYPE_SUPER
                               && super_ok && load_rise;
    assign ev[IRQ_ERR_BIT]   = state_reg == ST_ACT && cmd_type == TYPE_SUPER && !super_ok;
    assign ev[IRQ_STOP_BIT]  = stop_reg;

    // sticky status, cleared by read, set wins
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            status_reg <= '0;
            mask_reg   <= '0;
            irq_reg    <= 1'b0;
        end
        else
        begin
            if (rd_pulse && WB_ADR_I == REG_STATUS)
                status_reg <= ev;
            else
                status_reg <= status_reg | ev;
            if (wr_pulse && WB_ADR_I == REG_MASK && WB_SEL_I[0])
                mask_reg <= WB_DAT_I[IRQ_WIDTH-1:0];
            irq_reg <= |((status_reg | ev) & mask_reg);
        end
    end

    // read data mux, unmapped reads return zero
    always_comb
    begin
        rdata_next = ZERO32;
        case (WB_ADR_I)
            REG_MSG_LO: rdata_next = msg_lo_reg;
            REG_MSG_HI: rdata_next = msg_hi_reg;
            REG_CTRL:   rdata_next = {31'h0, state_reg != ST_IDLE};
            REG_STATUS: rdata_next = {27'h0, status_reg};
            REG_MASK:   rdata_next = {27'h0, mask_reg};
            REG_VEL:    rdata_next = vel_reg;
            REG_MODE:   rdata_next = {23'h0, in_cont_reg, mode_reg};
            REG_HOME:   rdata_next = {22'h0, home_dir_reg, home_arm_reg, home_type_reg};
            REG_POS:    rdata_next = pos_reg;
            REG_SUPER:  rdata_next = {30'h0, nvm_en_reg, alarm_clr_reg};
            REG_RESP:   rdata_next = {24'h0, resp_reg};
            default:    rdata_next = ZERO32;
        endcase
    end

    // registered read data
    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            WB_DAT_O <= ZERO32;
        else if (rd_pulse)
            WB_DAT_O <= rdata_next;
    end

    assign WB_ACK_O    = ack_w;
    assign IRQ         = irq_reg;
    assign SLEW_START  = slew_reg;
    assign HOME_START  = hstart_reg;
    assign HOME_CCW    = home_dir_reg;
    assign MOTION_STOP = stop_reg;

    // a homing launch needs a rising load bit on the decoded axis
    a_home_start_edge: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        HOME_START |-> $past(load_rise) && $past(cmd_type) == TYPE_HOME) // [RULE_08]
        else $error("homing started without load edge");
    // completion of homing zeroes the actual position
    a_home_pos_zero: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (home_done_ev && home_arm_reg) |=> pos_reg == ZERO32) // [RULE_09]
        else $error("position not cleared after homing");
    // continuous velocity takes bytes 4..7 as velocity
    a_cont_vel_load: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        SLEW_START |-> vel_reg == $past(msg_hi_reg) && mode_reg == MODE_VELOCITY) // [RULE_16]
        else $error("velocity slew without target");
    // stop after continuous velocity restores saved mode
    a_mode_restore: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        (state_reg == ST_ACT && ctl[CTL_ENABLE_BIT] && stop_req && in_cont_reg)
        |=> mode_reg == $past(saved_mode_reg) && !in_cont_reg) // [RULE_02]
        else $error("mode not restored on stop");
    // an invalid supervisor command gives the error type
    a_super_error: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ev[IRQ_ERR_BIT] |=> resp_reg[TYPE_HI:0] == TYPE_ERROR) // [RULE_13]
        else $error("no error response");
    // supervisor attributes change only on a load rise
    a_super_edge: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        ($changed(alarm_clr_reg) || $changed(nvm_en_reg)) |-> $past(ev[IRQ_SUPER_BIT])) // [RULE_14]
        else $error("supervisor write without load edge");
    // homing direction follows the direction bit
    a_home_dir: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        HOME_START |-> HOME_CCW == $past(ctl[CTL_DIR_BIT])) // [RULE_10]
        else $error("homing direction wrong");
    // ack lasts exactly one cycle
    a_ack_single: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
endmodule

// ===== test/mcd_motion_model.sv
/*
 * motion partner model: answers a homing launch with a done level after a delay.
 * assumes the decoder pulses home_start for one clock cycle.
 */
`timescale 1ns/10ps
module mcd_motion_model
#(
    parameter int DONE_DELAY = 60
)
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic home_start,
    output logic      home_done
);
    int count;
    // done drops at each launch and rises once the search has run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count     <= 0;
            home_done <= 1'b0;
        end
        else if (home_start)
        begin
            count     <= DONE_DELAY;
            home_done <= 1'b0;
        end
        else if (count > 0)
        begin
            count     <= count - 1;
            home_done <= (count == 1);
        end
    end
endmodule

// ===== test/mcd_decoder_tb.sv
/*
 * self-checking bench for the motion command decoder: wishbone master tasks,
 * a behavioural model of the decoder, checks of registers, pulses and irq.
 * assumes mcd_pkg, the decoder and the motion partner model are compiled first.
 */
`timescale 1ns/10ps
module mcd_decoder_tb;
    import mcd_pkg::*;
    logic        clk, rst_n, cyc, stb, we;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic        ack, irq, slew, hstart, ccw, mstop, hdone;
    int          err_count, num_checks, cycles, c_slew, c_home, c_stop;
    int          e_slew, e_home, e_stop, e_mode, p_mode, e_stat, e_super;
    int          prev_ld [NUM_AXES];

    mcd_decoder i_mcd_decoder (.CORE_CLK(clk), .RESET_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .HOME_DONE(hdone), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .IRQ(irq), .SLEW_START(slew), .HOME_START(hstart), .HOME_CCW(ccw),
        .MOTION_STOP(mstop));
    mcd_motion_model i_mcd_motion_model (.clk(clk), .reset_n(rst_n),
        .home_start(hstart), .home_done(hdone));

    // clock
    initial clk = 1'b0;
    always #20 clk = ~clk;

    // pulse counters and hang limit
    always @(posedge clk)
    begin
        cycles++;
        c_slew += (slew === 1'b1);
        c_home += (hstart === 1'b1);
        c_stop += (mstop === 1'b1);
        if (cycles == 30000)
        begin
            err_count++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // classic cycle: hold until ack, take data, release for one cycle
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // ack and read data are taken at the same rising edge
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask

    task automatic chk_irq(input logic exp);
        @(negedge clk);
        chk(irq, exp);
        @(posedge clk);
    endtask

    // model one command, send it, wait for idle, compare
    task automatic send(input logic [31:0] lo, input logic [31:0] hi);
        logic [7:0] b0;
        int ld, ax;
        b0 = lo[7:0];
        ax = lo[23:21];
        ld = b0[0] && prev_ld[ax] == 0;
        prev_ld[ax] = b0[0];
        if (lo[20:16] == TYPE_SUPER)
        begin
            if (lo[15:8] inside {ATTR_ALARM_CLR, ATTR_NVM_EN} &&
                lo[31:24] inside {ATTR_ALARM_CLR, ATTR_NVM_EN})
            begin
                if (ld && lo[31:24] == ATTR_NVM_EN) e_super = (e_super & 1) | (hi[0] << 1);
                else if (ld) e_super = (e_super & 2) | hi[0];
                if (ld) e_stat |= 4;
            end
            else e_stat |= 8;
        end
        else if (b0[7] && (b0[5] || b0[4]))
        begin
            e_stop++;
            e_stat |= 16;
            if (e_mode[8]) e_mode = p_mode;
        end
        else if (b0[7] && lo[20:16] == TYPE_CONT_VEL)
        begin
            if (!e_mode[8]) p_mode = e_mode;
            e_mode = 32'h101;
            e_slew++;
            e_stat |= 1;
        end
        else if (b0[7] && lo[20:16] == TYPE_HOME && hi[31:8] == 0 && ld) e_home++;
        wb(1'b1, REG_MSG_LO, lo, q);
        wb(1'b1, REG_MSG_HI, hi, q);
        wb(1'b1, REG_CTRL, 32'h0000_0001, q);
        do wb(1'b0, REG_CTRL, 32'h0, q); while (q[0] !== 1'b0);
        repeat (3) @(posedge clk);
        chk(c_slew, e_slew);
        chk(c_home, e_home);
        chk(c_stop, e_stop);
        rd(REG_MODE, e_mode);
        rd(REG_SUPER, e_super);
        if (lo[20:16] == TYPE_CONT_VEL && !b0[5] && !b0[4]) rd(REG_VEL, hi);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {cyc, stb, we, adr, wdat} = '0;
        rst_n = 1'b0;
        foreach (prev_ld[i]) prev_ld[i] = 0;
        void'($urandom(20));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(REG_MODE, 0);
        rd(REG_STATUS, 0);
        wb(1'b1, 6'h3C, 32'hFFFF_FFFF, q);
        rd(6'h3C, 0);
        $display("test reset done");
        // continuous velocity, then smooth stop and hard stop
        for (int s = 4; s <= 5; s++)
        begin
            wb(1'b1, REG_MASK, 32'h0000_001F, q);
            send(32'h0011_0080, $urandom());
            chk_irq(1'b1);
            rd(REG_STATUS, e_stat);
            e_stat = 0;
            chk_irq(1'b0);
            wb(1'b1, REG_MASK, 32'h0, q);
            send(32'h0011_0080 | (1 << s), 32'h0);
            chk_irq(1'b0);
            rd(REG_STATUS, e_stat);
            e_stat = 0;
        end
        $display("test velocity done");
        // homing fires on a rising load bit only
        wb(1'b1, REG_POS, $urandom(), q);
        send(32'h0012_0088, 32'h5);
        send(32'h0012_0089, 32'h5);
        chk(ccw, 1'b1);
        rd(REG_HOME, 32'h305);
        send(32'h0012_0089, 32'h5);
        while (hdone !== 1'b1) @(posedge clk);
        repeat (6) @(posedge clk);
        e_stat |= 2;
        rd(REG_POS, 0);
        rd(REG_STATUS, e_stat);
        send(32'h0012_0080, 32'h5);
        send(32'h0012_0081, 32'h5);
        chk(ccw, 1'b0);
        rd(REG_HOME, 32'h105);
        // software done while armed clears position and arm
        wb(1'b1, REG_POS, 32'h0000_00A5, q);
        wb(1'b1, REG_CTRL, 32'h0000_0002, q);
        rd(REG_POS, 0);
        rd(REG_HOME, 32'h005);
        send(32'h0012_0080, 32'h105);
        send(32'h0012_0081, 32'h105);
        repeat (100) @(posedge clk);
        rd(REG_STATUS, e_stat);
        e_stat = 0;
        $display("test homing done");
        // supervisor writes, then an invalid attribute
        send(32'h671A_6780, 32'h1);
        send(32'h671A_6781, 32'h1);
        send(32'h6F1A_6F80, 32'h1);
        send(32'h6F1A_6F81, 32'h1);
        send(32'h551A_6780, 32'h0);
        send(32'h551A_6781, 32'h0);
        rd(REG_STATUS, e_stat);
        rd(REG_RESP, {27'h0, TYPE_ERROR});
        $display("test supervisor done");
        conclude();
    end
endmodule
